// >>> verilog/sts_pkg.sv
// sequence timer scheduler constants, register indices and codes
package sts_pkg;

  // ---------------------------------------------------------------
  // sizing
  // ---------------------------------------------------------------
  localparam int STS_NTMR = 3;
  localparam int STS_NREG = 15;
  localparam int STS_FLDS = 5;
  localparam int STS_TW = 11;
  localparam int STS_AW = 16;
  localparam int STS_DW = 32;
  localparam int STS_SELW = 5;

  // ---------------------------------------------------------------
  // register indices, byte address is index times four
  // ---------------------------------------------------------------
  localparam logic [15:0] STS_IDX_T2_START = 16'h320B;
  localparam logic [15:0] STS_IDX_T2_STOP = 16'h320C;
  localparam logic [15:0] STS_IDX_T2_DAY = 16'h320D;
  localparam logic [15:0] STS_IDX_T2_ACT = 16'h320E;
  localparam logic [15:0] STS_IDX_T2_SRC = 16'h320F;
  localparam logic [15:0] STS_IDX_T3_START = 16'h3210;
  localparam logic [15:0] STS_IDX_T3_STOP = 16'h3211;
  localparam logic [15:0] STS_IDX_T3_DAY = 16'h3212;
  localparam logic [15:0] STS_IDX_T3_ACT = 16'h3213;
  localparam logic [15:0] STS_IDX_T3_SRC = 16'h3214;
  localparam logic [15:0] STS_IDX_T4_START = 16'h3215;
  localparam logic [15:0] STS_IDX_T4_STOP = 16'h3216;
  localparam logic [15:0] STS_IDX_T4_DAY = 16'h3217;
  localparam logic [15:0] STS_IDX_T4_ACT = 16'h3218;
  localparam logic [15:0] STS_IDX_T4_SRC = 16'h3219;
  localparam logic [15:0] STS_IDX_STATUS = 16'h3230;
  localparam int STS_ADDR_SHIFT = 2;
  localparam logic [4:0] STS_SEL_STATUS = 5'h0F;
  localparam logic [4:0] STS_SEL_NONE = 5'h1F;

  // field order inside one timer's group of five
  localparam logic [2:0] STS_F_START = 3'h0;
  localparam logic [2:0] STS_F_STOP = 3'h1;
  localparam logic [2:0] STS_F_DAY = 3'h2;
  localparam logic [2:0] STS_F_ACT = 3'h3;
  localparam logic [2:0] STS_F_SRC = 3'h4;

  // ---------------------------------------------------------------
  // value ranges and reset values
  // ---------------------------------------------------------------
  localparam logic [10:0] STS_TIME_MAX = 11'h5A0;
  localparam logic [10:0] STS_TIME_RST = 11'h000;
  localparam logic [3:0] STS_DAY_MAX = 4'hA;
  localparam logic [1:0] STS_ACT_MAX = 2'h2;
  localparam logic [2:0] STS_SRC_MAX = 3'h6;

  // day selection codes
  localparam logic [3:0] STS_DAY_OFF = 4'h0;
  localparam logic [3:0] STS_DAY_ALL = 4'h1;
  localparam logic [3:0] STS_DAY_WKDAY = 4'h2;
  localparam logic [3:0] STS_DAY_WKEND = 4'h3;
  localparam logic [3:0] STS_DAY_MON = 4'h4;

  // day of week from the calendar, monday first
  localparam logic [2:0] STS_DOW_SAT = 3'h5;
  localparam logic [2:0] STS_DOW_SUN = 3'h6;

  // action codes
  localparam logic [1:0] STS_ACT_DOUT = 2'h0;
  localparam logic [1:0] STS_ACT_RUN = 2'h1;
  localparam logic [1:0] STS_ACT_RUNPI = 2'h2;

  // reference source codes
  localparam logic [2:0] STS_SRC_PRESET_A = 3'h0;

endpackage : sts_pkg

// >>> verilog/sts_timer.sv
// sequence timers two to four: apb registers and time-of-day scheduling
//
// Implementation choice: register access over APB.
`timescale 1ns/10ps

module sts_timer
  import sts_pkg::*;
#(
  parameter int NTMR = sts_pkg::STS_NTMR
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sts_pkg::STS_AW-1:0] paddr,
  input wire logic [sts_pkg::STS_DW-1:0] pwdata,
  output logic [sts_pkg::STS_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [sts_pkg::STS_TW-1:0] time_of_day,
  input wire logic [2:0] day_of_week,
  output logic [NTMR-1:0] timer_dout,
  output logic run_cmd,
  output logic pi_disable,
  output logic [2:0] ref_source,
  output logic ref_valid
);
  import sts_pkg::*;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------

  // map a byte address to a register select, none when unmapped
  function automatic logic [STS_SELW-1:0] reg_sel(input logic [STS_AW-1:0] a);
    logic [STS_AW-1:0] idx;
    idx = a >> STS_ADDR_SHIFT;
    reg_sel = STS_SEL_NONE;
    if (a[STS_ADDR_SHIFT-1:0] == '0)
    begin
      if (idx >= STS_IDX_T2_START && idx <= STS_IDX_T4_SRC)
        reg_sel = STS_SELW'(idx - STS_IDX_T2_START);
      else if (idx == STS_IDX_STATUS)
        reg_sel = STS_SEL_STATUS;
    end
  endfunction : reg_sel

  // day selection code against the current weekday
  function automatic logic day_on(input logic [3:0] sel, input logic [2:0] dow);
    logic wkend;
    wkend = (dow == STS_DOW_SAT) || (dow == STS_DOW_SUN);
    day_on = 1'b0;
    if (sel == STS_DAY_ALL)
      day_on = 1'b1;
    else if (sel == STS_DAY_WKDAY)
      day_on = !wkend;
    else if (sel == STS_DAY_WKEND)
      day_on = wkend;
    else if (sel >= STS_DAY_MON && sel <= STS_DAY_MAX)
      day_on = (sel - STS_DAY_MON) == {1'b0, dow};
  endfunction : day_on

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [STS_TW-1:0] start_q [NTMR];
  logic [STS_TW-1:0] start_d [NTMR];
  logic [STS_TW-1:0] stop_q [NTMR];
  logic [STS_TW-1:0] stop_d [NTMR];
  logic [3:0] day_q [NTMR];
  logic [3:0] day_d [NTMR];
  logic [1:0] act_q [NTMR];
  logic [1:0] act_d [NTMR];
  logic [2:0] src_q [NTMR];
  logic [2:0] src_d [NTMR];
  logic [STS_DW-1:0] prdata_d;
  logic pready_d;
  logic pslverr_d;
  logic [NTMR-1:0] dout_d;
  logic run_d;
  logic pi_d;
  logic [2:0] ref_d;
  logic ref_valid_d;
  logic [NTMR-1:0] hit_w;
  logic [STS_SELW-1:0] sel_w;
  logic wr_w;

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------

  // a write lands only in the completing access cycle
  assign sel_w = reg_sel(paddr);
  assign wr_w = psel && penable && pready && pwrite;

  // register next values; out-of-range writes are dropped
  always_comb
  begin
    int t;
    int f;
    t = 0;
    f = 0;
    for (int i = 0; i < NTMR; i++)
    begin
      start_d[i] = start_q[i];
      stop_d[i] = stop_q[i];
      day_d[i] = day_q[i];
      act_d[i] = act_q[i];
      src_d[i] = src_q[i];
    end
    if (wr_w && sel_w < STS_SELW'(NTMR * STS_FLDS))
    begin
      t = int'(sel_w) / STS_FLDS;
      f = int'(sel_w) % STS_FLDS;
      unique case (3'(f))
        STS_F_START:
          if (pwdata <= STS_DW'(STS_TIME_MAX))
            start_d[t] = pwdata[STS_TW-1:0];
        STS_F_STOP:
          if (pwdata <= STS_DW'(STS_TIME_MAX))
            stop_d[t] = pwdata[STS_TW-1:0];
        STS_F_DAY:
          if (pwdata <= STS_DW'(STS_DAY_MAX))
            day_d[t] = pwdata[3:0];
        STS_F_ACT:
          if (pwdata <= STS_DW'(STS_ACT_MAX))
            act_d[t] = pwdata[1:0];
        STS_F_SRC:
          if (pwdata <= STS_DW'(STS_SRC_MAX))
            src_d[t] = pwdata[2:0];
        default: ;
      endcase
    end
  end

  // read data, ready and error prepared in the setup cycle
  always_comb
  begin
    int t;
    int f;
    t = int'(sel_w) / STS_FLDS;
    f = int'(sel_w) % STS_FLDS;
    prdata_d = prdata;
    pready_d = psel && !penable;
    pslverr_d = 1'b0;
    if (psel && !penable)
    begin
      prdata_d = '0;
      if (sel_w == STS_SEL_STATUS)
        prdata_d = STS_DW'({ref_valid, ref_source, pi_disable, run_cmd, timer_dout});
      else if (sel_w < STS_SELW'(NTMR * STS_FLDS))
      begin
        unique case (3'(f))
          STS_F_START: prdata_d = STS_DW'(start_q[t]);
          STS_F_STOP: prdata_d = STS_DW'(stop_q[t]);
          STS_F_DAY: prdata_d = STS_DW'(day_q[t]);
          STS_F_ACT: prdata_d = STS_DW'(act_q[t]);
          STS_F_SRC: prdata_d = STS_DW'(src_q[t]);
          default: prdata_d = '0;
        endcase
      end
      else
        pslverr_d = 1'b1; // unmapped address
    end
  end

  // ---------------------------------------------------------------
  // scheduling
  // ---------------------------------------------------------------

  // per-timer activity window
  for (genvar g = 0; g < NTMR; g++)
  begin : g_tmr
    assign hit_w[g] = day_on(day_q[g], day_of_week)
      && time_of_day >= start_q[g] && time_of_day < stop_q[g];

    // field ranges; out-of-range writes never reach the registers
    AST_START_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
      start_q[g] <= STS_TIME_MAX) else $error("start time above 24:00");
    AST_STOP_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
      stop_q[g] <= STS_TIME_MAX) else $error("stop time above 24:00");
    AST_DAY_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
      day_q[g] <= STS_DAY_MAX) else $error("day code out of range");
    AST_ACT_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
      act_q[g] <= STS_ACT_MAX) else $error("action code out of range");
    AST_SRC_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
      src_q[g] <= STS_SRC_MAX) else $error("reference source out of range");

    // writes land when in range and are dropped above it
    AST_START_WR: assert property (@(posedge pclk) disable iff (!presetn)
      wr_w && sel_w == STS_SELW'(g * STS_FLDS + int'(STS_F_START))
      && pwdata <= STS_DW'(STS_TIME_MAX) |=> start_q[g] == $past(pwdata[STS_TW-1:0]))
      else $error("start time write lost");
    AST_STOP_DROP: assert property (@(posedge pclk) disable iff (!presetn)
      wr_w && sel_w == STS_SELW'(g * STS_FLDS + int'(STS_F_STOP))
      && pwdata > STS_DW'(STS_TIME_MAX) |=> stop_q[g] == $past(stop_q[g]))
      else $error("stop time above 24:00 accepted");

    // day selection and interval
    AST_DAY_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      day_q[g] == STS_DAY_OFF |=> !timer_dout[g]) else $error("disabled timer active");
    AST_WEEKDAY: assert property (@(posedge pclk) disable iff (!presetn)
      day_q[g] == STS_DAY_WKDAY && day_of_week >= STS_DOW_SAT |=> !timer_dout[g])
      else $error("weekday timer active at weekend");
    AST_WEEKEND: assert property (@(posedge pclk) disable iff (!presetn)
      day_q[g] == STS_DAY_WKEND && day_of_week < STS_DOW_SAT |=> !timer_dout[g])
      else $error("weekend timer active on a weekday");
    AST_ONE_DAY: assert property (@(posedge pclk) disable iff (!presetn)
      day_q[g] >= STS_DAY_MON && day_q[g] - STS_DAY_MON != {1'b0, day_of_week}
      |=> !timer_dout[g]) else $error("single day timer active on another day");
    AST_WINDOW: assert property (@(posedge pclk) disable iff (!presetn)
      day_q[g] == STS_DAY_ALL && time_of_day >= start_q[g] && time_of_day < stop_q[g]
      |=> timer_dout[g]) else $error("daily timer missed its window");
    AST_BEFORE_START: assert property (@(posedge pclk) disable iff (!presetn)
      time_of_day < start_q[g] |=> !timer_dout[g]) else $error("active before start time");
    AST_STOP_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
      time_of_day == stop_q[g] |=> !timer_dout[g]) else $error("active at stop time");

    // action of an active timer
    AST_DOUT_ACT: assert property (@(posedge pclk) disable iff (!presetn)
      hit_w[g] && act_q[g] == STS_ACT_DOUT |=> timer_dout[g])
      else $error("digital output missing for active timer");
    AST_RUN_ACT: assert property (@(posedge pclk) disable iff (!presetn)
      hit_w[g] && act_q[g] != STS_ACT_DOUT |=> run_cmd && ref_valid)
      else $error("running timer gave no run command");
  end

  // combine timers; lowest numbered running timer picks the reference
  always_comb
  begin
    dout_d = hit_w;
    run_d = 1'b0;
    pi_d = 1'b0;
    ref_d = STS_SRC_PRESET_A;
    ref_valid_d = 1'b0;
    for (int i = NTMR - 1; i >= 0; i--)
    begin
      if (hit_w[i] && act_q[i] != STS_ACT_DOUT)
      begin
        run_d = 1'b1;
        ref_d = src_q[i];
        ref_valid_d = 1'b1;
      end
      if (hit_w[i] && act_q[i] == STS_ACT_RUNPI)
        pi_d = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------

  // all state and outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NTMR; i++)
      begin
        start_q[i] <= STS_TIME_RST;
        stop_q[i] <= STS_TIME_RST;
        day_q[i] <= STS_DAY_OFF;
        act_q[i] <= STS_ACT_DOUT;
        src_q[i] <= STS_SRC_PRESET_A;
      end
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      timer_dout <= '0;
      run_cmd <= 1'b0;
      pi_disable <= 1'b0;
      ref_source <= STS_SRC_PRESET_A;
      ref_valid <= 1'b0;
    end
    else
    begin
      start_q <= start_d;
      stop_q <= stop_d;
      day_q <= day_d;
      act_q <= act_d;
      src_q <= src_d;
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
      timer_dout <= dout_d;
      run_cmd <= run_d;
      pi_disable <= pi_d;
      ref_source <= ref_d;
      ref_valid <= ref_valid_d;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------

  // combined run, pi and reference outputs
  AST_DOUT_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    run_cmd |-> $past(hit_w[0] && act_q[0] != STS_ACT_DOUT
    || hit_w[1] && act_q[1] != STS_ACT_DOUT || hit_w[2] && act_q[2] != STS_ACT_DOUT))
    else $error("run without a running timer");
  AST_RUN: assert property (@(posedge pclk) disable iff (!presetn)
    hit_w[0] && act_q[0] == STS_ACT_RUN |=> run_cmd && !pi_disable || $past(hit_w[1]
    || hit_w[2])) else $error("run action not run");
  AST_PI_RUN: assert property (@(posedge pclk) disable iff (!presetn)
    pi_disable |-> run_cmd) else $error("pi disabled without run");
  AST_REF_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)
    !run_cmd |-> !ref_valid && ref_source == STS_SRC_PRESET_A)
    else $error("reference applied without run");
  AST_TMR4: assert property (@(posedge pclk) disable iff (!presetn)
    hit_w[2] && act_q[2] == STS_ACT_RUNPI |=> pi_disable && run_cmd)
    else $error("fourth timer action ignored");
  AST_REF_SEL: assert property (@(posedge pclk) disable iff (!presetn)
    hit_w[0] && act_q[0] != STS_ACT_DOUT |=> ref_source == $past(src_q[0]))
    else $error("wrong reference source");
  AST_REF_VALID: assert property (@(posedge pclk) disable iff (!presetn)
    ref_valid == run_cmd) else $error("reference valid differs from run");

  // apb answer: one access cycle, error only for unmapped addresses
  AST_READY: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready ##1 !pready) else $error("ready not one cycle");
  AST_ERR_PAIR: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready) else $error("error without ready");
  AST_ERR_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && sel_w == STS_SEL_NONE |=> pslverr && pready)
    else $error("unmapped address not refused");
  AST_ERR_MAPPED: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && sel_w != STS_SEL_NONE |=> !pslverr)
    else $error("mapped address refused");
  AST_RD_STATUS: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && sel_w == STS_SEL_STATUS
    |=> prdata == STS_DW'($past({ref_valid, ref_source, pi_disable, run_cmd, timer_dout})))
    else $error("status read differs from outputs");
  AST_RD_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !(psel && !penable) |=> $stable(prdata)) else $error("read data changed outside a read");

endmodule : sts_timer

// >>> sim/sts_timer_tb.sv
// self-checking bench for the sequence timer scheduler over apb
`timescale 1ns/10ps
module sts_timer_tb;
  import sts_pkg::*;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [STS_AW-1:0] paddr;
  logic [STS_DW-1:0] pwdata;
  logic [STS_DW-1:0] prdata;
  logic [STS_DW-1:0] rd;
  logic pready;
  logic pslverr;
  logic perr;
  logic [STS_TW-1:0] tod;
  logic [2:0] dow;
  logic [2:0] timer_dout;
  logic [2:0] ref_source;
  logic run_cmd;
  logic pi_disable;
  logic ref_valid;
  int err_total;
  int check_count;
  int tv[4] = '{59, 60, 119, 120};

  sts_timer u_sts_timer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .time_of_day(tod), .day_of_week(dow), .timer_dout(timer_dout), .run_cmd(run_cmd),
    .pi_disable(pi_disable), .ref_source(ref_source), .ref_valid(ref_valid)
  );

  // ---------------------------------------------------------------
  // clock and helpers
  // ---------------------------------------------------------------
  // 25 mhz clock
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic summarize();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, index times four gives the byte address
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= idx << STS_ADDR_SHIFT;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (n == 20)
    begin
      err_total++;
      $display("ERROR %0t: no pready", $time);
      summarize();
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [15:0] idx, input logic [31:0] v);
    apb(1'b1, idx, v);
    repeat (2) @(posedge pclk);
  endtask : wr

  task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp);
    chk({31'h0, perr}, 32'h0);
  endtask : rdchk

  task automatic setin(input logic [10:0] t, input logic [2:0] d);
    @(posedge pclk);
    tod <= t;
    dow <= d;
    repeat (2) @(posedge pclk);
  endtask : setin

  // compares every scheduler output; ref_valid mirrors run
  task automatic outchk(input logic [2:0] d, input logic r, input logic p, input logic [2:0] s);
    chk({23'h0, ref_valid, ref_source, pi_disable, run_cmd, timer_dout},
        {23'h0, r, s, p, r, d});
  endtask : outchk

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  // reset, then register and schedule scenarios
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0;
    pwdata = 32'h0;
    tod = 11'h0;
    dow = 3'h0;
    err_total = 0;
    check_count = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 15; i++)
      rdchk(STS_IDX_T2_START + i[15:0], 32'h0);
    apb(1'b0, 16'h3200, 32'h0);
    chk({31'h0, perr}, 32'h1);
    wr(STS_IDX_T2_START, 32'h5A1);
    rdchk(STS_IDX_T2_START, 32'h0);
    wr(STS_IDX_T2_STOP, 32'h5A0);
    rdchk(STS_IDX_T2_STOP, 32'h5A0);
    wr(STS_IDX_T2_START, 32'h5A0);
    rdchk(STS_IDX_T2_START, 32'h5A0);
    wr(STS_IDX_T2_STOP, 32'h5A1);
    rdchk(STS_IDX_T2_STOP, 32'h5A0);
    wr(STS_IDX_T2_DAY, 32'hB);
    rdchk(STS_IDX_T2_DAY, 32'h0);
    wr(STS_IDX_T2_ACT, 32'h3);
    rdchk(STS_IDX_T2_ACT, 32'h0);
    wr(STS_IDX_T2_SRC, 32'h7);
    rdchk(STS_IDX_T2_SRC, 32'h0);
    wr(STS_IDX_T2_START, 32'h3C);
    wr(STS_IDX_T2_STOP, 32'h78);
    setin(11'h5A, 3'h0);
    outchk(3'h0, 1'b0, 1'b0, 3'h0);
    // day codes one to ten against every weekday
    for (int c = 1; c <= 10; c++)
    begin
      wr(STS_IDX_T2_DAY, c);
      for (int d = 0; d < 7; d++)
      begin
        setin(11'h5A, d[2:0]);
        chk(timer_dout[0], (c == 1) || (c == 2 && d < 5) || (c == 3 && d >= 5) || (c == d + 4));
      end
    end
    // interval edges, start inclusive and stop exclusive
    wr(STS_IDX_T2_DAY, 32'h1);
    for (int k = 0; k < 4; k++)
    begin
      setin(tv[k][10:0], 3'h2);
      chk(timer_dout[0], tv[k] >= 60 && tv[k] < 120);
    end
    // every action and source on timer three, whole day
    wr(STS_IDX_T2_DAY, 32'h0);
    wr(STS_IDX_T3_STOP, 32'h5A0);
    wr(STS_IDX_T3_DAY, 32'h1);
    for (int a = 0; a < 3; a++)
      for (int s = 0; s < 7; s++)
      begin
        wr(STS_IDX_T3_ACT, a);
        wr(STS_IDX_T3_SRC, s);
        outchk(3'h2, a != 0, a == 2, (a != 0) ? s[2:0] : 3'h0);
      end
    // fourth timer runs on its own settings, lowest timer's source wins
    wr(STS_IDX_T4_STOP, 32'h5A0);
    wr(STS_IDX_T4_DAY, 32'h1);
    wr(STS_IDX_T4_ACT, 32'h2);
    wr(STS_IDX_T4_SRC, 32'h6);
    wr(STS_IDX_T3_ACT, 32'h1);
    wr(STS_IDX_T3_SRC, 32'h3);
    outchk(3'h6, 1'b1, 1'b1, 3'h3);
    // status mirrors the outputs and ignores writes
    rdchk(STS_IDX_STATUS, 32'h17E);
    wr(STS_IDX_STATUS, 32'h0);
    rdchk(STS_IDX_STATUS, 32'h17E);
    wr(STS_IDX_T3_ACT, 32'h0);
    outchk(3'h6, 1'b1, 1'b1, 3'h6);
    wr(STS_IDX_T4_ACT, 32'h1);
    outchk(3'h6, 1'b1, 1'b0, 3'h6);
    // timer two runs from the terminals inside its window and wins the reference
    wr(STS_IDX_T2_ACT, 32'h1);
    wr(STS_IDX_T2_SRC, 32'h4);
    wr(STS_IDX_T2_DAY, 32'h1);
    setin(11'h5A, 3'h2);
    outchk(3'h7, 1'b1, 1'b0, 3'h4);
    // reset in mid-run returns every field and output to its default
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    outchk(3'h0, 1'b0, 1'b0, 3'h0);
    for (int i = 0; i < 15; i++)
      rdchk(STS_IDX_T2_START + i[15:0], 32'h0);
    outchk(3'h0, 1'b0, 1'b0, 3'h0);
    summarize();
  end
endmodule : sts_timer_tb
